// file: hdl/shp_defs.svh
`ifndef SHP_DEFS_SVH
`define SHP_DEFS_SVH

`define SHP_BYTE_W 8
`define SHP_ADDR_W 7
`define SHP_REG_FRAME_BITS 5'd16
`define SHP_FIFO_FRAME_BITS 5'd8
`define SHP_ADDR_LAST_BIT 5'd7
`define SHP_DATA_LAST_BIT 5'd15
`define SHP_RW_READ 1'b1
`define SHP_FIFO_DEPTH 32
`define SHP_FIFO_TH 32
`define SHP_CLK_NS 40
`define SHP_SCLK_HALF 4
`define SHP_FIFO_SETUP_HALVES 2
`define SHP_FIFO_HOLD_NS 2000
`define SHP_FIFO_GAP_NS 4000
`define SHP_FIFO_HOLD_CYC ((`SHP_FIFO_HOLD_NS + `SHP_CLK_NS - 1) / `SHP_CLK_NS)
`define SHP_FIFO_GAP_CYC ((`SHP_FIFO_GAP_NS + `SHP_CLK_NS - 1) / `SHP_CLK_NS)
`define SHP_TMR_W 8

`endif

// file: hdl/shp_device.sv
`timescale 1ns/1ns
`include "shp_defs.svh"

module shp_device #(
  parameter int DEPTH = `SHP_FIFO_DEPTH,
  parameter int THRESH = `SHP_FIFO_TH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  shp_if.device link,
  input wire logic sleep,
  input wire logic fifo_wr_valid,
  input wire shp_pkg::shp_byte_t fifo_wr_data,
  output logic fifo_wr_ready,
  output logic fifo_not_empty,
  output logic fifo_at_thresh,
  output logic fifo_full,
  output logic reg_wr_valid,
  output shp_pkg::shp_addr_t reg_wr_addr,
  output shp_pkg::shp_byte_t reg_wr_data
);
  import shp_pkg::*;

  localparam int PW = $clog2(DEPTH);
  localparam int REG_DEPTH = 1 << `SHP_ADDR_W;
  localparam logic [PW:0] DEPTH_C = (PW + 1)'(DEPTH);
  localparam logic [PW:0] THRESH_C = (PW + 1)'(THRESH);

  // link side, cleared whenever both selects are high
  typedef struct packed {
    logic [4:0] cnt;
    logic rw;
    shp_addr_t addr;
    shp_byte_t data;
    shp_byte_t rd;
  } shp_dpos_s;

  // link side, survives between frames
  typedef struct packed {
    logic wr_tog;
    logic pop_tog;
    shp_addr_t hold_addr;
    shp_byte_t hold_data;
  } shp_dkeep_s;

  typedef struct packed {
    logic started;
    logic out;
    logic oe;
  } shp_dneg_s;

  typedef struct packed {
    logic [PW:0] wptr;
    logic [PW:0] rptr;
    shp_byte_t head;
    logic fsel1;
    logic fsel2;
    logic pop1;
    logic pop2;
    logic pop_seen;
    logic wt1;
    logic wt2;
    logic wt_seen;
    logic open;
    logic ready;
    logic nmty;
    logic th;
    logic full;
    logic reg_wr_valid;
    shp_addr_t reg_wr_addr;
    shp_byte_t reg_wr_data;
  } shp_dclk_s;

  shp_dpos_s p_q;
  shp_dpos_s p_d;
  shp_dkeep_s k_q;
  shp_dkeep_s k_d;
  shp_dneg_s n_q;
  shp_dneg_s n_d;
  shp_dclk_s c_q;
  shp_dclk_s c_d;

  shp_byte_t regs [REG_DEPTH];
  shp_byte_t fifo_mem [DEPTH];
  logic reg_we;
  logic push;
  logic pop;
  logic reg_frame;
  logic fifo_frame;
  logic frame_rst;
  logic [PW:0] count_d;

  function automatic logic [2:0] shp_bit_idx(input logic [4:0] last,
                                             input logic [4:0] cnt);
    shp_bit_idx = 3'(last - cnt);
  endfunction

  // register select wins if the host breaks the exclusion
  assign reg_frame = !link.register_select_n;
  assign fifo_frame = !link.fifo_select_n &&
    link.register_select_n;
  // selects are the only marker of frame end; sclk stops outside frames
  assign frame_rst = rst || (link.register_select_n && link.fifo_select_n);

  always_comb begin
    p_d = p_q;
    k_d = k_q;
    reg_we = 1'b0;
    if (p_q.cnt != `SHP_REG_FRAME_BITS) begin
      p_d.cnt = p_q.cnt + 5'd1;
    end
    if (reg_frame) begin
      // direction bit, then address, then one data byte, MSB first
      if (p_q.cnt == 5'd0) begin
        p_d.rw = link.sda;
      end else if (p_q.cnt <= `SHP_ADDR_LAST_BIT) begin
        p_d.addr = {p_q.addr[`SHP_ADDR_W-2:0], link.sda};
      end else if (p_q.cnt <= `SHP_DATA_LAST_BIT) begin
        p_d.data = {p_q.data[`SHP_BYTE_W-2:0], link.sda};
      end
      if (p_q.cnt == `SHP_ADDR_LAST_BIT) begin
        p_d.rd = regs[{p_q.addr[`SHP_ADDR_W-2:0], link.sda}];
      end
      if (p_q.cnt == `SHP_DATA_LAST_BIT && p_q.rw != `SHP_RW_READ) begin
        reg_we = 1'b1;
        k_d.hold_addr = p_q.addr;
        k_d.hold_data = {p_q.data[`SHP_BYTE_W-2:0], link.sda};
        k_d.wr_tog = !k_q.wr_tog;
      end
    end else if (fifo_frame && p_q.cnt == `SHP_FIFO_FRAME_BITS - 5'd1) begin
      k_d.pop_tog = !k_q.pop_tog;
    end
  end

  // data sampled on the rising edge
  always_ff @(posedge link.sclk or posedge frame_rst) begin
    if (frame_rst) begin
      p_q <= '0;
    end else begin
      p_q <= p_d;
    end
  end

  always_ff @(posedge link.sclk or posedge rst) begin
    if (rst) begin
      k_q <= '0;
    end else begin
      k_q <= k_d;
    end
  end

  always_ff @(posedge link.sclk) begin
    if (reg_we) begin
      regs[k_d.hold_addr] <= k_d.hold_data;
    end
  end

  always_comb begin
    n_d = n_q;
    n_d.started = 1'b1;
    n_d.oe = 1'b0;
    if (reg_frame) begin
      // drive only after the address; released after the last bit
      if (p_q.rw == `SHP_RW_READ && p_q.cnt > `SHP_ADDR_LAST_BIT
          && p_q.cnt <= `SHP_DATA_LAST_BIT) begin
        n_d.oe = 1'b1;
        n_d.out = p_q.rd[shp_bit_idx(`SHP_DATA_LAST_BIT, p_q.cnt)];
      end
    end else if (fifo_frame && p_q.cnt < `SHP_FIFO_FRAME_BITS) begin
      n_d.out = c_q.head[shp_bit_idx(`SHP_FIFO_FRAME_BITS - 5'd1, p_q.cnt)];
    end
  end

  // bits launched on the falling edge
  always_ff @(negedge link.sclk or posedge frame_rst) begin
    if (frame_rst) begin
      n_q <= '0;
    end else begin
      n_q <= n_d;
    end
  end

  // fifo msb must sit on the line before any edge, so it comes from head
  assign link.dev_sda_o = n_q.started ? n_q.out :
    c_q.head[`SHP_BYTE_W-1];
  // fifo frames drive from select low; blocked in sleep
  assign link.dev_sda_oe = n_q.oe ||
    (fifo_frame && c_q.open);

  always_comb begin
    c_d = c_q;
    c_d.reg_wr_valid = 1'b0;
    c_d.fsel1 = link.fifo_select_n;
    c_d.fsel2 = c_q.fsel1;
    c_d.pop1 = k_q.pop_tog;
    c_d.pop2 = c_q.pop1;
    c_d.pop_seen = c_q.pop2;
    c_d.wt1 = k_q.wr_tog;
    c_d.wt2 = c_q.wt1;
    c_d.wt_seen = c_q.wt2;
    c_d.open = !sleep;
    // held words are stable for a whole frame after the toggle
    if (c_q.wt2 != c_q.wt_seen) begin
      c_d.reg_wr_valid = 1'b1;
      c_d.reg_wr_addr = k_q.hold_addr;
      c_d.reg_wr_data = k_q.hold_data;
    end
    push = fifo_wr_valid && c_q.ready;
    pop = (c_q.pop2 != c_q.pop_seen) && c_q.open && (c_q.wptr != c_q.rptr);
    if (push) begin
      c_d.wptr = c_q.wptr + 1'b1;
    end
    if (pop) begin
      c_d.rptr = c_q.rptr + 1'b1;
    end
    count_d = c_d.wptr - c_d.rptr;
    c_d.ready = count_d != DEPTH_C;
    // head and flags frozen while the select is low
    if (c_q.fsel2) begin
      c_d.head = fifo_mem[c_d.rptr[PW-1:0]];
      c_d.nmty = count_d != '0;
      c_d.th = count_d >= THRESH_C;
      c_d.full = count_d == DEPTH_C;
    end
    if (rst) begin
      c_d = '0;
      c_d.fsel1 = 1'b1;
      c_d.fsel2 = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || ce) begin
      c_q <= c_d;
    end
  end

  always_ff @(posedge clk) begin
    if (ce && !rst && push) begin
      fifo_mem[c_q.wptr[PW-1:0]] <= fifo_wr_data;
    end
  end

  assign fifo_wr_ready = c_q.ready;
  assign fifo_not_empty = c_q.nmty;
  assign fifo_at_thresh = c_q.th;
  assign fifo_full = c_q.full;
  assign reg_wr_valid = c_q.reg_wr_valid;
  assign reg_wr_addr = c_q.reg_wr_addr;
  assign reg_wr_data = c_q.reg_wr_data;

endmodule

// file: hdl/shp_host.sv
`timescale 1ns/1ns
`include "shp_defs.svh"

module shp_host #(
  parameter int SCLK_HALF = `SHP_SCLK_HALF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  shp_if.host link,
  input wire logic cmd_valid,
  input wire shp_pkg::shp_cmd_e cmd_kind,
  input wire shp_pkg::shp_addr_t cmd_addr,
  input wire shp_pkg::shp_byte_t cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output shp_pkg::shp_byte_t rsp_data
);
  import shp_pkg::*;

  localparam logic [`SHP_TMR_W-1:0] HALF = `SHP_TMR_W'(SCLK_HALF);
  localparam logic [`SHP_TMR_W-1:0] FSETUP =
    `SHP_TMR_W'(SCLK_HALF * `SHP_FIFO_SETUP_HALVES);
  localparam logic [`SHP_TMR_W-1:0] FHOLD = `SHP_TMR_W'(`SHP_FIFO_HOLD_CYC);
  localparam logic [`SHP_TMR_W-1:0] FGAP = `SHP_TMR_W'(`SHP_FIFO_GAP_CYC);

  typedef struct packed {
    shp_hstate_e state;
    shp_cmd_e kind;
    logic [15:0] sh;
    shp_byte_t rx;
    logic [4:0] bits;
    logic [`SHP_TMR_W-1:0] tmr;
    logic [`SHP_TMR_W-1:0] gap;
    logic rsel_n;
    logic fsel_n;
    logic sclk;
    logic sda_o;
    logic sda_oe;
    logic sda1;
    logic sda2;
    logic ready;
    logic rsp_valid;
    shp_byte_t rsp_data;
  } shp_host_s;

  shp_host_s h_q;
  shp_host_s h_d;
  logic fifo;
  logic [4:0] nbits;

  assign fifo = h_q.kind == SHP_CMD_FIFO_RD;
  assign nbits = fifo ? `SHP_FIFO_FRAME_BITS : `SHP_REG_FRAME_BITS;

  always_comb begin
    h_d = h_q;
    h_d.rsp_valid = 1'b0;
    h_d.sda1 = link.sda;
    h_d.sda2 = h_q.sda1;
    if (h_q.tmr != '0) begin
      h_d.tmr = h_q.tmr - 1'b1;
    end
    if (h_q.gap != '0) begin
      h_d.gap = h_q.gap - 1'b1;
    end
    case (h_q.state)
      SHP_H_IDLE: begin
        h_d.ready = h_q.gap <= 8'd1;
        if (cmd_valid && h_q.ready) begin
          h_d.ready = 1'b0;
          h_d.kind = cmd_kind;
          h_d.bits = 5'd0;
          h_d.sh = {cmd_kind == SHP_CMD_REG_RD, cmd_addr,
                    cmd_wdata};
          // one select at a time, never both
          if (cmd_kind == SHP_CMD_FIFO_RD) begin
            h_d.fsel_n = 1'b0;
            h_d.sda_oe = 1'b0;
            h_d.tmr = FSETUP;
          end else begin
            h_d.rsel_n = 1'b0;
            h_d.sda_oe = 1'b1;
            h_d.sda_o = cmd_kind == SHP_CMD_REG_RD;
            h_d.tmr = HALF;
          end
          h_d.state = SHP_H_SETUP;
        end
      end
      SHP_H_SETUP, SHP_H_LOW: begin
        if (h_q.tmr <= 8'd1) begin
          // synced line, driven half a period earlier
          h_d.sclk = 1'b1;
          h_d.rx = {h_q.rx[6:0], h_q.sda2};
          h_d.bits = h_q.bits + 5'd1;
          h_d.tmr = HALF;
          h_d.state = SHP_H_HIGH;
        end
      end
      SHP_H_HIGH: begin
        if (h_q.tmr <= 8'd1) begin
          h_d.sclk = 1'b0;
          h_d.sh = {h_q.sh[14:0], 1'b0};
          h_d.sda_o = h_q.sh[14];
          // released once the device owns the line
          h_d.sda_oe = !fifo && (h_q.kind == SHP_CMD_REG_WR
            || h_q.bits < `SHP_FIFO_FRAME_BITS);
          if (h_q.bits == nbits) begin
            h_d.sda_oe = 1'b0;
            h_d.tmr = fifo ? FHOLD : HALF;
            h_d.state = SHP_H_HOLD;
          end else begin
            h_d.tmr = HALF;
            h_d.state = SHP_H_LOW;
          end
        end
      end
      SHP_H_HOLD: begin
        if (h_q.tmr <= 8'd1) begin
          h_d.rsel_n = 1'b1;
          h_d.fsel_n = 1'b1;
          h_d.rsp_valid = 1'b1;
          h_d.rsp_data = h_q.rx;
          h_d.gap = fifo ? FGAP : 8'd1;
          h_d.state = SHP_H_IDLE;
        end
      end
      default: begin
        h_d.state = SHP_H_IDLE;
      end
    endcase
    if (rst) begin
      h_d = '0;
      h_d.rsel_n = 1'b1;
      h_d.fsel_n = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || ce) begin
      h_q <= h_d;
    end
  end

  assign link.register_select_n = h_q.rsel_n;
  assign link.fifo_select_n = h_q.fsel_n;
  assign link.sclk = h_q.sclk;
  assign link.host_sda_o = h_q.sda_o;
  assign link.host_sda_oe = h_q.sda_oe;
  assign cmd_ready = h_q.ready;
  assign rsp_valid = h_q.rsp_valid;
  assign rsp_data = h_q.rsp_data;

endmodule

// file: hdl/shp_if.sv
`timescale 1ns/1ns

interface shp_if;
  logic register_select_n;
  logic fifo_select_n;
  logic sclk;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;

  // undriven line floats high through the pull-up
  assign sda = dev_sda_oe ? dev_sda_o : (host_sda_oe ? host_sda_o : 1'b1);

  modport device (
    input register_select_n,
    input fifo_select_n,
    input sclk,
    input sda,
    output dev_sda_o,
    output dev_sda_oe
  );

  modport host (
    output register_select_n,
    output fifo_select_n,
    output sclk,
    output host_sda_o,
    output host_sda_oe,
    input sda
  );
endinterface

// file: hdl/shp_pkg.sv
`include "shp_defs.svh"

package shp_pkg;

  typedef logic [`SHP_BYTE_W-1:0] shp_byte_t;
  typedef logic [`SHP_ADDR_W-1:0] shp_addr_t;

  typedef enum logic [1:0] {
    SHP_CMD_REG_WR = 2'b00,
    SHP_CMD_REG_RD = 2'b01,
    SHP_CMD_FIFO_RD = 2'b10
  } shp_cmd_e;

  typedef enum logic [2:0] {
    SHP_H_IDLE = 3'b000,
    SHP_H_SETUP = 3'b001,
    SHP_H_HIGH = 3'b010,
    SHP_H_LOW = 3'b011,
    SHP_H_HOLD = 3'b100
  } shp_hstate_e;

endpackage

// file: verification/shp_checker.sv
`timescale 1ns/1ns

module shp_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic register_select_n,
  input wire logic fifo_select_n,
  input wire logic sclk,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic [7:0] low_q;
  logic [7:0] high_q;

  // saturate so a long idle span never wraps into a short one
  always_ff @(posedge clk) begin
    if (rst || sclk) begin
      low_q <= 8'h00;
    end else if (low_q != 8'hFF) begin
      low_q <= low_q + 8'h01;
    end
    // reset value saturated: no earlier byte read to space from
    if (rst) begin
      high_q <= 8'hFF;
    end else if (!fifo_select_n) begin
      high_q <= 8'h00;
    end else if (high_q != 8'hFF) begin
      high_q <= high_q + 8'h01;
    end
  end

  chk_sel_excl: assert property (
    register_select_n || fifo_select_n)
    else $error("both selects low");
  chk_host_launch: assert property (
    host_sda_oe && $past(host_sda_oe) && $changed(host_sda_o) |-> $fell(sclk))
    else $error("host data moved off falling edge");
  chk_dev_launch: assert property (
    dev_sda_oe && $past(dev_sda_oe) && $changed(dev_sda_o) |-> $fell(sclk))
    else $error("device data moved off falling edge");
  chk_line_owner: assert property (!(host_sda_oe && dev_sda_oe))
    else $error("both ends drive data line");
  chk_dev_selected: assert property (
    dev_sda_oe |-> !register_select_n || !fifo_select_n)
    else $error("device drives while unselected");
  chk_reg_setup: assert property (
    $fell(register_select_n) |-> !sclk [*4])
    else $error("register select set-up too short");
  chk_reg_hold: assert property ($rose(register_select_n) |->
    !$past(sclk) && !$past(sclk, 2) && !$past(sclk, 3) && !$past(sclk, 4))
    else $error("register select hold too short");
  chk_fifo_setup: assert property (
    $fell(fifo_select_n) |-> !sclk [*8])
    else $error("fifo select set-up too short");
  chk_fifo_hold: assert property (
    $rose(fifo_select_n) |-> low_q >= 8'h32)
    else $error("fifo select hold too short");
  chk_fifo_gap: assert property (
    $fell(fifo_select_n) |-> high_q >= 8'h64)
    else $error("fifo select gap too short");
endmodule

// file: verification/testbench.sv
`timescale 1ns/1ns

module testbench;
  import shp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sleep = 1'b0;
  logic ce = 1'b1;
  logic fifo_wr_valid = 1'b0;
  shp_byte_t fifo_wr_data = 8'h00;
  logic cmd_valid = 1'b0;
  shp_cmd_e cmd_kind = SHP_CMD_REG_WR;
  shp_addr_t cmd_addr = 7'h00;
  shp_byte_t cmd_wdata = 8'h00;
  logic fifo_wr_ready, fifo_not_empty, fifo_at_thresh, fifo_full;
  logic reg_wr_valid, cmd_ready, rsp_valid;
  shp_addr_t reg_wr_addr, wr_addr;
  shp_byte_t reg_wr_data, rsp_data, wr_data;
  logic [15:0] bits = 16'h0000;
  int nbits = 0;
  int wr_cnt = 0;
  int failures = 0;
  int num_checks = 0;

  always #20 clk = ~clk;

  shp_if link ();
  shp_host #(.SCLK_HALF(4)) i_shp_host (.clk(clk), .rst(rst), .ce(ce),
    .link(link.host), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  shp_device i_shp_device (.clk(clk), .rst(rst), .ce(ce),
    .link(link.device), .sleep(sleep), .fifo_wr_valid(fifo_wr_valid),
    .fifo_wr_data(fifo_wr_data), .fifo_wr_ready(fifo_wr_ready),
    .fifo_not_empty(fifo_not_empty), .fifo_at_thresh(fifo_at_thresh),
    .fifo_full(fifo_full), .reg_wr_valid(reg_wr_valid),
    .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data));
  shp_checker chk (.clk(clk), .rst(rst),
    .register_select_n(link.register_select_n),
    .fifo_select_n(link.fifo_select_n), .sclk(link.sclk),
    .host_sda_o(link.host_sda_o), .host_sda_oe(link.host_sda_oe),
    .dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe));

  // wire view: what either end sees at each rising serial clock
  always @(posedge link.sclk) begin
    if (!link.register_select_n || !link.fifo_select_n) begin
      bits = {bits[14:0], link.sda};
      nbits++;
    end
  end

  always @(posedge clk) begin
    if (reg_wr_valid === 1'b1) begin
      wr_addr = reg_wr_addr;
      wr_data = reg_wr_data;
      wr_cnt++;
    end
  end

  task check(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      failures++;
    end
  endtask

  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task timeout;
    check("handshake", 16'h0000, 16'h0001);
    finish_test();
  endtask

  // hold valid up to the edge that takes it, then wait for the answer
  task cmd(input shp_cmd_e k, input shp_addr_t a, input shp_byte_t d);
    int i;
    @(posedge clk);
    for (i = 0; cmd_ready !== 1'b1; i++) begin
      if (i > 300) timeout();
      @(posedge clk);
    end
    nbits = 0;
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    for (i = 0; rsp_valid !== 1'b1; i++) begin
      if (i > 300) timeout();
      @(posedge clk);
    end
  endtask

  task push(input shp_byte_t b);
    int i;
    @(posedge clk);
    fifo_wr_valid <= 1'b1;
    fifo_wr_data <= b;
    @(posedge clk);
    for (i = 0; fifo_wr_ready !== 1'b1; i++) begin
      if (i > 300) timeout();
      @(posedge clk);
    end
    fifo_wr_valid <= 1'b0;
  endtask

  // boundary addresses; second pass runs asleep, port must still work
  task automatic t_reg;
    shp_addr_t a[2] = '{7'h00, 7'h7F};
    shp_byte_t d[2] = '{8'h5A, 8'hC3};
    int n;
    for (int j = 0; j < 2; j++) begin
      sleep <= (j == 1);
      n = wr_cnt;
      cmd(SHP_CMD_REG_WR, a[j], d[j]);
      check("wire_wr", bits, {1'b0, a[j], d[j]});
      check("wire_wr_bits", 16'(nbits), 16'h0010);
      check("wr_pulse", 16'(wr_cnt - n), 16'h0001);
      check("wr_addr", 16'(wr_addr), 16'(a[j]));
      check("wr_data", 16'(wr_data), 16'(d[j]));
    end
    for (int j = 0; j < 2; j++) begin
      n = wr_cnt;
      cmd(SHP_CMD_REG_RD, a[j], 8'h00);
      check("rd_data", 16'(rsp_data), 16'(d[j]));
      check("wire_rd", bits, {1'b1, a[j], d[j]});
      check("rd_no_write", 16'(wr_cnt - n), 16'h0000);
    end
    sleep <= 1'b0;
    $display("test reg done");
  endtask

  task t_fifo;
    // a write offered while the enable is low must not land
    ce <= 1'b0;
    fifo_wr_valid <= 1'b1;
    repeat (8) @(posedge clk);
    fifo_wr_valid <= 1'b0;
    ce <= 1'b1;
    repeat (4) @(posedge clk);
    check("ce_frozen", 16'(fifo_not_empty), 16'h0000);
    for (int i = 0; i < 32; i++) push(shp_byte_t'(8'h40 + i));
    repeat (10) @(posedge clk);
    check("full", 16'(fifo_full), 16'h0001);
    check("thresh", 16'(fifo_at_thresh), 16'h0001);
    check("wr_ready", 16'(fifo_wr_ready), 16'h0000);
    sleep <= 1'b1;
    cmd(SHP_CMD_FIFO_RD, 7'h00, 8'h00);
    check("sleep_rd", 16'(rsp_data), 16'h00FF);
    sleep <= 1'b0;
    for (int i = 0; i < 32; i++) begin
      cmd(SHP_CMD_FIFO_RD, 7'h00, 8'h00);
      check("fifo_data", 16'(rsp_data), 16'(8'h40 + i));
      check("wire_fifo", 16'(bits[7:0]), 16'(8'h40 + i));
      check("wire_fifo_bits", 16'(nbits), 16'h0008);
      if (i == 1) begin
        check("full_gap", 16'(fifo_full), 16'h0000);
      end
    end
    repeat (10) @(posedge clk);
    check("not_empty", 16'(fifo_not_empty), 16'h0000);
    $display("test fifo done");
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reg();
    t_fifo();
    finish_test();
  end
endmodule
